// ---- rtl/host_port_pkg.sv ----
/*
 * Shared constants and state types for the 8-bit parallel host port:
 * bus style codes, pin vector layout, reset values and cycle counts.
 * Assumes both ends run on one 100 MHz clock and see the bus pins as
 * asynchronous inputs.
 */
// What this block does
// - separate-strobe style: data captured on write rise
// - enable style: direction pin high reads, low writes
// - address-strobe style: direction pin high reads, low writes
// - respond only while select is low
// - separate-strobe: wait low, then high, then released
// - address-strobe: acknowledge high, then low, then released
// - host may hold access until handshake completes
// - enable style: wait output left unconnected
// - address strobe held high outside address-strobe style
// - address strobe low qualifies the cycle
// - reset clears state, outputs go inactive
// - scan and test ties held at ground
// - separate-strobe: drive data only while read low
// - enable style: transfer when enable goes high
// - two straps select the bus style
// - low address bit tags indirect access kind
`default_nettype none

package host_port_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // bus style strap codes
    localparam logic [1:0] STYLE_STROBE = 2'h0;
    localparam logic [1:0] STYLE_ENABLE = 2'h1;
    localparam logic [1:0] STYLE_ADDR = 2'h2;

    // device pin vector layout
    localparam int PIN_W = 16;
    localparam int PIN_STRAP_LO = 0;
    localparam int PIN_INDIRECT = 2;
    localparam int PIN_CS = 3;
    localparam int PIN_RD = 4;
    localparam int PIN_WR = 5;
    localparam int PIN_AS = 6;
    localparam int PIN_A0 = 7;
    localparam int PIN_DATA_LO = 8;
    localparam logic [15:0] PIN_RST = 16'h0078;

    localparam logic [7:0] DATA_PULL = 8'hFF;

    // device cycles between start of access and completion
    localparam int BUSY_CYCLES = 2;

    // host phase lengths in cycles
    localparam int SETUP_CYCLES = 2;
    localparam int STROBE_CYCLES = 8;
    localparam int HOLD_CYCLES = 4;
    localparam int HS_TIMEOUT_CYCLES = 64;

    typedef enum logic [1:0] {DEV_IDLE, DEV_BUSY, DEV_DONE} dev_state_t;
    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} host_state_t;

endpackage

`default_nettype wire

// ---- rtl/host_bus_if.sv ----
/*
 * Pin-level carrier between host end and device end of the port.
 * Resolves the shared data bus and the pulled-up wait line from the
 * output enables of both ends.
 */
`timescale 1ns/1ps
`default_nettype none

interface host_bus_if;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic as_n;
    logic lowest_address_bit;
    logic [7:0] host_dout;
    logic host_doe;
    logic [7:0] dev_dout;
    logic dev_doe;
    logic [7:0] data;
    logic wait_out;
    logic wait_oe;
    logic wait_level;
    logic [1:0] bus_style_straps;
    logic addressing_mode_strap;
    logic scan_mode_tie;
    logic test_mode_tie;

    // released lines float to the pull-up level
    assign data = dev_doe ? dev_dout : (host_doe ? host_dout : host_port_pkg::DATA_PULL);
    assign wait_level = wait_oe ? wait_out : 1'b1;

    modport host_end (
        output cs_n, rd_n, wr_n, as_n, lowest_address_bit, host_dout, host_doe,
        output bus_style_straps, addressing_mode_strap, scan_mode_tie, test_mode_tie,
        input data, wait_level
    );

    modport dev_end (
        input cs_n, rd_n, wr_n, as_n, lowest_address_bit, data,
        input bus_style_straps, addressing_mode_strap, scan_mode_tie, test_mode_tie,
        output dev_dout, dev_doe, wait_out, wait_oe
    );
endinterface

`default_nettype wire

// ---- rtl/host_port_host.sv ----
/*
 * Host end: turns single user requests into bus cycles in the selected
 * style and returns read data. Assumes the device end sits on the
 * same interface; drives the straps and test ties like a board would.
 */
`timescale 1ns/1ps
`default_nettype none

module host_port_host (
    input wire logic clk_sys,
    input wire logic rst_n,
    host_bus_if.host_end bus,
    input wire logic [1:0] bus_style,
    input wire logic indirect,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_a0,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic done,
    output logic [7:0] rdata
);
    typedef struct packed {
        logic w_s1;
        logic w_s2;
        logic [7:0] d_s1;
        logic [7:0] d_s2;
        host_port_pkg::host_state_t state;
        logic [7:0] cnt;
        logic seen_busy;
        logic write;
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic as_n;
        logic a0;
        logic [7:0] wdata;
        logic doe;
        logic done;
        logic [7:0] rdata;
    } host_st_t;

    host_st_t q;
    host_st_t d;
    logic hs;
    logic hs_done;

    always_comb
    begin
        d = q;
        d.w_s1 = bus.wait_level;
        d.w_s2 = q.w_s1;
        d.d_s1 = bus.data;
        d.d_s2 = q.d_s1;
        d.done = 1'b0;
        hs = indirect && (bus_style != host_port_pkg::STYLE_ENABLE);
        hs_done = (bus_style == host_port_pkg::STYLE_ADDR) ? !q.w_s2 : (q.seen_busy && q.w_s2);
        case (q.state)
            host_port_pkg::H_IDLE:
            begin
                if (req_valid)
                begin
                    d.state = host_port_pkg::H_SETUP;
                    d.cnt = 8'(host_port_pkg::SETUP_CYCLES);
                    d.cs_n = 1'b0;
                    d.a0 = req_a0;
                    d.write = req_write;
                    d.wdata = req_wdata;
                    d.doe = req_write;
                    d.rd_n = (bus_style != host_port_pkg::STYLE_ENABLE);
                    // direction select: high reads, low writes
                    d.wr_n = (bus_style == host_port_pkg::STYLE_STROBE) ? 1'b1 : !req_write;
                end
            end
            host_port_pkg::H_SETUP:
            begin
                d.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01)
                begin
                    d.state = host_port_pkg::H_STROBE;
                    d.cnt = 8'h00;
                    d.seen_busy = 1'b0;
                    if (bus_style == host_port_pkg::STYLE_STROBE)
                    begin
                        d.wr_n = !q.write;
                        d.rd_n = q.write;
                    end
                    else if (bus_style == host_port_pkg::STYLE_ENABLE)
                        d.rd_n = 1'b1;
                    else
                    begin
                        d.as_n = 1'b0;
                        d.rd_n = 1'b0;
                    end
                end
            end
            host_port_pkg::H_STROBE:
            begin
                d.cnt = q.cnt + 8'h01;
                if ((bus_style == host_port_pkg::STYLE_STROBE) && !q.w_s2)
                    d.seen_busy = 1'b1;
                if ((!hs && q.cnt >= 8'(host_port_pkg::STROBE_CYCLES)) ||
                    (hs && (hs_done || q.cnt >= 8'(host_port_pkg::HS_TIMEOUT_CYCLES))))
                begin
                    d.state = host_port_pkg::H_HOLD;
                    d.cnt = 8'h00;
                    if (!q.write)
                        d.rdata = q.d_s2;
                    d.rd_n = (bus_style != host_port_pkg::STYLE_ENABLE);
                    d.as_n = 1'b1;
                    if (bus_style == host_port_pkg::STYLE_STROBE)
                        d.wr_n = 1'b1;
                end
            end
            host_port_pkg::H_HOLD:
            begin
                d.cnt = q.cnt + 8'h01;
                if (q.cnt >= 8'(host_port_pkg::HOLD_CYCLES))
                begin
                    d.state = host_port_pkg::H_IDLE;
                    d.cs_n = 1'b1;
                    d.wr_n = 1'b1;
                    d.rd_n = (bus_style != host_port_pkg::STYLE_ENABLE);
                    d.doe = 1'b0;
                    d.done = 1'b1;
                end
            end
            default:
                d.state = host_port_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.w_s1 <= 1'b1;
            q.w_s2 <= 1'b1;
            q.cs_n <= 1'b1;
            q.rd_n <= 1'b1;
            q.wr_n <= 1'b1;
            q.as_n <= 1'b1;
        end
        else
            q <= d;
    end

    assign bus.cs_n = q.cs_n;
    assign bus.rd_n = q.rd_n;
    assign bus.wr_n = q.wr_n;
    assign bus.as_n = q.as_n;
    assign bus.lowest_address_bit = q.a0;
    assign bus.host_dout = q.wdata;
    assign bus.host_doe = q.doe;
    assign bus.bus_style_straps = bus_style;
    assign bus.addressing_mode_strap = indirect;
    assign bus.scan_mode_tie = 1'b0;
    assign bus.test_mode_tie = 1'b0;
    assign req_ready = (q.state == host_port_pkg::H_IDLE);
    assign done = q.done;
    assign rdata = q.rdata;
endmodule

`default_nettype wire

// ---- rtl/host_port_device.sv ----
/*
 * Device end of the parallel host port: decodes the three bus styles,
 * runs the wait/acknowledge handshake, drives read data and hands
 * written bytes to the display core. Assumes every bus pin and strap
 * is asynchronous to clk_sys; the core answers reads from read_data.
 */
`timescale 1ns/1ps
`default_nettype none

module host_port_device #(
    parameter int BUSY = host_port_pkg::BUSY_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    host_bus_if.dev_end bus,
    input wire logic [7:0] read_data,
    output logic read_taken,
    output logic write_valid,
    output logic [7:0] write_data,
    output logic access_kind,
    output logic [1:0] bus_style,
    output logic indirect_mode
);
    typedef struct packed {
        logic [15:0] s1;
        logic [15:0] s2;
        logic [15:0] s3;
        logic act;
        host_port_pkg::dev_state_t state;
        logic [3:0] cnt;
        logic write;
        logic kind;
        logic [7:0] dout;
        logic doe;
        logic wait_out;
        logic wait_oe;
        logic rd_pulse;
        logic wr_pulse;
        logic [7:0] wdata;
    } dev_st_t;

    dev_st_t q;
    dev_st_t d;

    logic [15:0] pins;
    logic cs;
    logic rd_low;
    logic wr_low;
    logic as_low;
    logic [1:0] style;
    logic act;
    logic finish;
    logic busy_level;

    // all pins and straps packed for one synchroniser chain
    assign pins = {bus.data, bus.lowest_address_bit, bus.as_n, bus.wr_n, bus.rd_n,
                   bus.cs_n, bus.addressing_mode_strap, bus.bus_style_straps};

    always_comb
    begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.rd_pulse = 1'b0;
        d.wr_pulse = 1'b0;
        finish = 1'b0;

        // decode from second synchroniser stage only
        cs = !q.s2[host_port_pkg::PIN_CS];
        rd_low = !q.s2[host_port_pkg::PIN_RD];
        wr_low = !q.s2[host_port_pkg::PIN_WR];
        as_low = !q.s2[host_port_pkg::PIN_AS];
        style = q.s2[host_port_pkg::PIN_STRAP_LO +: 2];

        // level that stalls the host while busy
        busy_level = (style == host_port_pkg::STYLE_ADDR);

        case (style)
            host_port_pkg::STYLE_ENABLE:
                act = cs && !rd_low;
            host_port_pkg::STYLE_ADDR:
                act = cs && as_low && rd_low;
            default:
                act = cs && (rd_low || wr_low);
        endcase
        d.act = act;

        case (q.state)
            host_port_pkg::DEV_IDLE:
            begin
                d.wait_oe = 1'b0;
                if (act)
                begin
                    d.state = host_port_pkg::DEV_BUSY;
                    d.cnt = 4'(BUSY - 1);
                    // pin high reads, low writes in both select styles
                    d.write = wr_low;
                    d.kind = q.s2[host_port_pkg::PIN_A0];
                    if (style != host_port_pkg::STYLE_ENABLE)
                    begin
                        d.wait_oe = 1'b1;
                        d.wait_out = busy_level;
                    end
                    if (!wr_low)
                    begin
                        d.dout = read_data;
                        d.rd_pulse = 1'b1;
                    end
                    else if (style != host_port_pkg::STYLE_STROBE)
                    begin
                        // enable rise or strobed cycle: data valid now
                        d.wdata = q.s2[host_port_pkg::PIN_DATA_LO +: 8];
                        d.wr_pulse = 1'b1;
                    end
                end
            end
            host_port_pkg::DEV_BUSY:
            begin
                if (!act)
                    finish = 1'b1;
                else if (q.cnt == 4'h0)
                begin
                    d.state = host_port_pkg::DEV_DONE;
                    // inactive level marks completion
                    d.wait_out = !busy_level;
                end
                else
                    d.cnt = q.cnt - 4'h1;
            end
            host_port_pkg::DEV_DONE:
            begin
                if (!act)
                    finish = 1'b1;
            end
            default:
                d.state = host_port_pkg::DEV_IDLE;
        endcase

        if (finish)
        begin
            d.state = host_port_pkg::DEV_IDLE;
            d.wait_oe = 1'b0;
            if (q.write && style == host_port_pkg::STYLE_STROBE)
            begin
                // byte as it stood just before the write strobe rose
                d.wdata = q.s3[host_port_pkg::PIN_DATA_LO +: 8];
                d.wr_pulse = 1'b1;
            end
        end

        // drivers only for a selected read cycle
        d.doe = act && !wr_low;
        if (style == host_port_pkg::STYLE_ENABLE)
            d.wait_oe = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.s1 <= host_port_pkg::PIN_RST;
            q.s2 <= host_port_pkg::PIN_RST;
            q.s3 <= host_port_pkg::PIN_RST;
        end
        else
            q <= d;
    end

    assign bus.dev_dout = q.dout;
    assign bus.dev_doe = q.doe;
    assign bus.wait_out = q.wait_out;
    assign bus.wait_oe = q.wait_oe;
    assign read_taken = q.rd_pulse;
    assign write_valid = q.wr_pulse;
    assign write_data = q.wdata;
    assign access_kind = q.kind;
    assign bus_style = q.s2[host_port_pkg::PIN_STRAP_LO +: 2];
    assign indirect_mode = q.s2[host_port_pkg::PIN_INDIRECT];
endmodule

`default_nettype wire

// ---- testbench/host_port_monitor.sv ----
/*
 * Checker for the parallel host port pins between host end and device end.
 * Assumes it is instantiated beside the interface, fed by its plain signals.
 */
`timescale 1ns/1ps
`default_nettype none

module host_port_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic as_n,
    input wire logic dev_doe,
    input wire logic wait_out,
    input wire logic wait_oe,
    input wire logic [1:0] bus_style_straps,
    input wire logic addressing_mode_strap,
    input wire logic scan_mode_tie,
    input wire logic test_mode_tie
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_wait_low;
        wait_oe && !wait_out;
    endsequence
    sequence s_wait_high;
        wait_oe && wait_out;
    endsequence

    property p_wait_strobe;
        $rose(wait_oe) && bus_style_straps == host_port_pkg::STYLE_STROBE
            |-> s_wait_low ##[1:8] s_wait_high;
    endproperty
    property p_ack_addr;
        $rose(wait_oe) && bus_style_straps == host_port_pkg::STYLE_ADDR
            |-> s_wait_high ##[1:8] s_wait_low;
    endproperty
    property p_hold_access;
        $rose(wait_oe) && bus_style_straps == host_port_pkg::STYLE_STROBE
            && addressing_mode_strap |-> (!rd_n || !wr_n) until_with s_wait_high;
    endproperty
    property p_no_select;
        cs_n [*5] |-> !wait_oe;
    endproperty
    property p_data_off;
        cs_n [*4] |-> !dev_doe;
    endproperty
    property p_read_drive;
        (bus_style_straps == host_port_pkg::STYLE_STROBE && rd_n) [*4] |-> !dev_doe;
    endproperty
    property p_enable_nowait;
        (bus_style_straps == host_port_pkg::STYLE_ENABLE) [*5] |-> !wait_oe;
    endproperty
    property p_as_high;
        bus_style_straps != host_port_pkg::STYLE_ADDR |-> as_n;
    endproperty
    property p_as_qualify;
        $rose(wait_oe) && bus_style_straps == host_port_pkg::STYLE_ADDR
            |-> !as_n && !$past(as_n);
    endproperty
    property p_ties;
        !scan_mode_tie && !test_mode_tie;
    endproperty

    a_wait_strobe: assert property (p_wait_strobe)
        else $error("wait sequence wrong in strobe style");
    a_ack_addr: assert property (p_ack_addr)
        else $error("acknowledge sequence wrong in address style");
    a_hold_access: assert property (p_hold_access)
        else $error("host released strobe before handshake");
    a_no_select: assert property (p_no_select)
        else $error("wait driven without select");
    a_data_off: assert property (p_data_off)
        else $error("data driven without select");
    a_read_drive: assert property (p_read_drive)
        else $error("data driven without read strobe");
    a_enable_nowait: assert property (p_enable_nowait)
        else $error("wait driven in enable style");
    a_as_high: assert property (p_as_high)
        else $error("address strobe low outside address style");
    a_as_qualify: assert property (p_as_qualify)
        else $error("access started without address strobe");
    a_ties: assert property (p_ties)
        else $error("scan or test tie not low");
endmodule

`default_nettype wire

// ---- testbench/testbench.sv ----
/*
 * Self-checking bench: host end and device end joined by the interface.
 * Assumes a 100 MHz clock; user-side inputs change at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] bus_style = 2'h0;
    logic indirect = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_a0 = 1'b0;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready, done, read_taken, write_valid, access_kind, indirect_mode;
    logic [7:0] rdata, write_data, dev_rd, got;
    logic [1:0] dev_style;
    logic [7:0] wr_seen = 8'h00;
    logic [7:0] wr_cnt = 8'h00;
    logic [7:0] rd_cnt = 8'h00;
    int failures = 0;
    int samples_checked = 0;

    always #5 clk_sys = ~clk_sys;

    host_bus_if bus();
    host_port_host i_host_port_host (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
        .bus_style(bus_style), .indirect(indirect), .req_valid(req_valid),
        .req_write(req_write), .req_a0(req_a0), .req_wdata(req_wdata),
        .req_ready(req_ready), .done(done), .rdata(rdata));
    host_port_device i_host_port_device (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
        .read_data(dev_rd), .read_taken(read_taken), .write_valid(write_valid),
        .write_data(write_data), .access_kind(access_kind), .bus_style(dev_style),
        .indirect_mode(indirect_mode));
    host_port_monitor i_host_port_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
        .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .as_n(bus.as_n),
        .dev_doe(bus.dev_doe), .wait_out(bus.wait_out), .wait_oe(bus.wait_oe),
        .bus_style_straps(bus.bus_style_straps),
        .addressing_mode_strap(bus.addressing_mode_strap),
        .scan_mode_tie(bus.scan_mode_tie), .test_mode_tie(bus.test_mode_tie));

    // record what the device hands to the core
    always @(posedge clk_sys)
    begin
        if (write_valid === 1'b1)
        begin
            wr_seen <= write_data;
            wr_cnt <= wr_cnt + 8'h01;
        end
        if (read_taken === 1'b1)
            rd_cnt <= rd_cnt + 8'h01;
    end

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic seen);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic access(input logic wr, input logic a0, input logic [7:0] wd,
                          output logic [7:0] rd);
        int n;
        n = 0;
        @(negedge clk_sys);
        req_valid = 1'b1;
        req_write = wr;
        req_a0 = a0;
        req_wdata = wd;
        @(negedge clk_sys);
        req_valid = 1'b0;
        check_bit("cs_n in access", 1'b0, bus.cs_n);
        check_bit("req_ready in access", 1'b0, req_ready);
        while (done !== 1'b1 && n < 200)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 200)
        begin
            failures++;
            $display("ERROR done expected 1 seen %b", done);
        end
        rd = rdata;
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        wrap_up();
    end

    initial
    begin
        logic [7:0] cnt;
        logic [7:0] wcnt;
        dev_rd = 8'h00;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int s = 0; s < 3; s++)
        begin
            for (int ind = 0; ind < 2; ind++)
            begin
                bus_style = s[1:0];
                indirect = ind[0];
                repeat (6) @(negedge clk_sys);
                check_byte("bus_style", {6'h00, s[1:0]}, {6'h00, dev_style});
                check_bit("indirect_mode", ind[0], indirect_mode);
                check_bit("dev_doe idle", 1'b0, bus.dev_doe);
                check_bit("wait_level idle", 1'b1, bus.wait_level);
                cnt = wr_cnt;
                access(1'b1, 1'b1, 8'hA5 ^ {4'h0, s[1:0], ind[0], 1'b0}, got);
                check_byte("write_data", 8'hA5 ^ {4'h0, s[1:0], ind[0], 1'b0}, wr_seen);
                check_byte("write count", cnt + 8'h01, wr_cnt);
                check_bit("access_kind write", 1'b1, access_kind);
                cnt = rd_cnt;
                wcnt = wr_cnt;
                dev_rd = 8'h3C + {5'h00, s[1:0], ind[0]};
                access(1'b0, 1'b0, 8'h00, got);
                check_byte("rdata", 8'h3C + {5'h00, s[1:0], ind[0]}, got);
                check_byte("read count", cnt + 8'h01, rd_cnt);
                check_bit("access_kind read", 1'b0, access_kind);
                check_byte("write count after read", wcnt, wr_cnt);
                check_bit("req_ready after access", 1'b1, req_ready);
                $display("test style %0d indirect %0d done", s, ind);
            end
        end
        // reset in the middle of a read
        bus_style = host_port_pkg::STYLE_STROBE;
        indirect = 1'b0;
        repeat (6) @(negedge clk_sys);
        req_valid = 1'b1;
        req_write = 1'b0;
        @(negedge clk_sys);
        req_valid = 1'b0;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b0;
        #1;
        check_bit("dev_doe in reset", 1'b0, bus.dev_doe);
        check_bit("wait_oe in reset", 1'b0, bus.wait_oe);
        check_bit("cs_n in reset", 1'b1, bus.cs_n);
        check_bit("done in reset", 1'b0, done);
        check_bit("write_valid in reset", 1'b0, write_valid);
        check_byte("write_data in reset", 8'h00, write_data);
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        dev_rd = 8'hC3;
        access(1'b0, 1'b1, 8'h00, got);
        check_byte("rdata after reset", 8'hC3, got);
        $display("test reset done");
        wrap_up();
    end
endmodule

`default_nettype wire
